// *** rtl/ptx_phy_end.sv ***
// phy end of the transmit port: makes the transmit clock, takes and packs data
//
// Contract
// - nibble mode clock 25 or 2.5 mhz
// - reduced mode: no tx clock, shared reference
// - serial mode clock is 10 mhz
// - mac drives serial data on tx clock
// - nibble data valid only while enable high
// - two-bit data valid only while enable high
// - serial data valid only while enable high
// - nibble data taken on own tx clock
// - two-bit data taken on shared reference clock
// - serial data on bit zero, others unused
module ptx_phy_end #(
    parameter int CNT_W = ptx_pkg::PTX_CNT_W_DEF
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input ptx_pkg::ptx_mode_e mode_in,
    input wire logic fast_in,
    ptx_if.phy link,
    output logic [ptx_pkg::PTX_BYTE_W-1:0] byte_out,
    output logic byte_valid_out,
    output logic frame_start_out,
    output logic frame_end_out,
    output logic frag_out,
    output logic in_frame_out,
    output ptx_pkg::ptx_mode_e mode_out,
    output logic fast_out
);
    import ptx_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (PTX_NIB_SLOW_CYC >= (2 ** CNT_W)) begin : g_bad_cnt
        $error("ptx_phy_end: CNT_W too narrow for the slowest clock");
    end
    if (PTX_NIB_FAST_CYC < 2) begin : g_bad_rate
        $error("ptx_phy_end: core clock too slow for the fast clock");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    ptx_mode_e act_mode; // mode in force
    logic act_fast; // speed in force
    ptx_mode_e next_act_mode;
    logic next_act_fast;
    logic [CNT_W-1:0] div_high; // high phase length for the divider
    logic [CNT_W-1:0] div_low; // low phase length for the divider
    logic div_run; // divider running
    logic div_clk; // divided clock level
    logic div_rise; // divided clock rises at this edge
    logic strobe; // sample point for link data
    logic [PTX_TXD_W-1:0] sym; // masked data symbol
    logic [3:0] sym_bits; // bits per symbol in this mode
    logic [PTX_BYTE_W-1:0] acc; // byte being packed
    logic [3:0] acc_bits; // bits already packed
    logic in_frame; // frame in progress
    logic [PTX_BYTE_W-1:0] next_acc;
    logic [3:0] next_acc_bits;
    logic next_in_frame;
    logic [PTX_BYTE_W-1:0] next_byte;
    logic next_byte_valid;
    logic next_start;
    logic next_end;
    logic next_frag;

    // ------------------------------------------------------------
    // mode and speed latch
    // ------------------------------------------------------------
    // new settings take effect only while the link is idle
    always_comb begin
        next_act_mode = act_mode;
        next_act_fast = act_fast;
        if (!in_frame && !link.tx_en) begin
            next_act_mode = mode_in;
            next_act_fast = fast_in;
        end
    end

    // register the settings
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            act_mode <= PTX_MODE_NIBBLE;
            act_fast <= 1'b1;
        end else if (ce_in) begin
            act_mode <= next_act_mode;
            act_fast <= next_act_fast;
        end
    end

    // ------------------------------------------------------------
    // transmit clock generation
    // ------------------------------------------------------------
    // phase lengths by mode and speed
    always_comb begin
        div_run = 1'b1;
        div_high = CNT_W'(PTX_NIB_FAST_HI);
        div_low = CNT_W'(PTX_NIB_FAST_LO);
        case (act_mode)
            PTX_MODE_NIBBLE: begin
                if (!act_fast) begin
                    div_high = CNT_W'(PTX_NIB_SLOW_HI);
                    div_low = CNT_W'(PTX_NIB_SLOW_LO);
                end
            end
            PTX_MODE_SERIAL: begin
                div_high = CNT_W'(PTX_SER_HI);
                div_low = CNT_W'(PTX_SER_LO);
            end
            default: begin
                div_run = 1'b0;
            end
        endcase
    end

    // divider for the transmit clock
    ptx_clk_div #(
        .CNT_W(CNT_W)
    ) u_div (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .run_in(div_run),
        .high_in(div_high),
        .low_in(div_low),
        .clk_out(div_clk),
        .rise_out(div_rise)
    );

    // clock pin held low in reduced mode, where it is unused
    assign link.tx_clk = (act_mode == PTX_MODE_REDUCED) ? 1'b0 : div_clk;

    // ------------------------------------------------------------
    // sample point and symbol masking
    // ------------------------------------------------------------
    always_comb begin
        strobe = div_rise;
        sym = link.txd;
        sym_bits = PTX_BITS_NIB;
        case (act_mode)
            PTX_MODE_REDUCED: begin
                strobe = ce_in;
                sym = {2'b00, link.txd[1:0]};
                sym_bits = PTX_BITS_RED;
            end
            PTX_MODE_SERIAL: begin
                sym = {3'b000, link.txd[PTX_SER_BIT]};
                sym_bits = PTX_BITS_SER;
            end
            default: ;
        endcase
    end

    // ------------------------------------------------------------
    // frame tracking and byte packing
    // ------------------------------------------------------------
    // symbols pack lsb first; a partial byte at the end is dropped
    always_comb begin
        next_acc = acc;
        next_acc_bits = acc_bits;
        next_in_frame = in_frame;
        next_byte = byte_out;
        next_byte_valid = 1'b0;
        next_start = 1'b0;
        next_end = 1'b0;
        next_frag = 1'b0;
        if (strobe) begin
            if (link.tx_en) begin
                next_in_frame = 1'b1;
                next_start = !in_frame;
                // place the symbol above the bits already held
                case (act_mode)
                    PTX_MODE_NIBBLE: next_acc[acc_bits[2:0] +: 4] = sym;
                    PTX_MODE_REDUCED: next_acc[acc_bits[2:0] +: 2] = sym[1:0];
                    default: next_acc[acc_bits[2:0]] = sym[0];
                endcase
                if (acc_bits + sym_bits == PTX_BYTE_BITS) begin
                    // byte complete
                    next_byte = next_acc;
                    next_byte_valid = 1'b1;
                    next_acc_bits = 4'h0;
                    next_acc = '0;
                end else begin
                    next_acc_bits = acc_bits + sym_bits;
                end
            end else if (in_frame) begin
                // enable fell: frame over
                next_in_frame = 1'b0;
                next_end = 1'b1;
                next_frag = (acc_bits != 4'h0);
                next_acc_bits = 4'h0;
                next_acc = '0;
            end
        end
    end

    // register packer state and outputs
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc <= '0;
            acc_bits <= 4'h0;
            in_frame <= 1'b0;
            byte_out <= '0;
            byte_valid_out <= 1'b0;
            frame_start_out <= 1'b0;
            frame_end_out <= 1'b0;
            frag_out <= 1'b0;
        end else if (ce_in) begin
            acc <= next_acc;
            acc_bits <= next_acc_bits;
            in_frame <= next_in_frame;
            byte_out <= next_byte;
            byte_valid_out <= next_byte_valid;
            frame_start_out <= next_start;
            frame_end_out <= next_end;
            frag_out <= next_frag;
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    assign in_frame_out = in_frame;
    assign mode_out = act_mode;
    assign fast_out = act_fast;
endmodule // ptx_phy_end

// *** rtl/ptx_pkg.sv ***
// shared constants and types for the mac-facing transmit port
package ptx_pkg;

    // ------------------------------------------------------------
    // clock rates
    // ------------------------------------------------------------
    localparam int unsigned PTX_CORE_HZ = 50_000_000; // core clock, also the shared reference
    localparam int unsigned PTX_NIB_FAST_HZ = 25_000_000; // nibble mode, 100 mb/s
    localparam int unsigned PTX_NIB_SLOW_HZ = 2_500_000; // nibble mode, 10 mb/s
    localparam int unsigned PTX_SER_HZ = 10_000_000; // one-bit serial mode

    // ------------------------------------------------------------
    // transmit clock periods in core cycles, split high / low
    // ------------------------------------------------------------
    localparam int unsigned PTX_NIB_FAST_CYC = PTX_CORE_HZ / PTX_NIB_FAST_HZ;
    localparam int unsigned PTX_NIB_SLOW_CYC = PTX_CORE_HZ / PTX_NIB_SLOW_HZ;
    localparam int unsigned PTX_SER_CYC = PTX_CORE_HZ / PTX_SER_HZ;
    localparam int unsigned PTX_NIB_FAST_HI = PTX_NIB_FAST_CYC / 2;
    localparam int unsigned PTX_NIB_FAST_LO = PTX_NIB_FAST_CYC - PTX_NIB_FAST_HI;
    localparam int unsigned PTX_NIB_SLOW_HI = PTX_NIB_SLOW_CYC / 2;
    localparam int unsigned PTX_NIB_SLOW_LO = PTX_NIB_SLOW_CYC - PTX_NIB_SLOW_HI;
    localparam int unsigned PTX_SER_HI = PTX_SER_CYC / 2;
    localparam int unsigned PTX_SER_LO = PTX_SER_CYC - PTX_SER_HI;

    // ------------------------------------------------------------
    // widths and field positions
    // ------------------------------------------------------------
    localparam int PTX_TXD_W = 4; // data lines on the link
    localparam int PTX_BYTE_W = 8; // user-side data unit
    localparam int PTX_CNT_W_DEF = 8; // default divider counter width
    localparam int PTX_SER_BIT = 0; // serial data rides on line zero
    localparam logic [3:0] PTX_BITS_NIB = 4'h4;
    localparam logic [3:0] PTX_BITS_RED = 4'h2;
    localparam logic [3:0] PTX_BITS_SER = 4'h1;
    localparam logic [3:0] PTX_BYTE_BITS = 4'h8;

    // ------------------------------------------------------------
    // interface modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PTX_MODE_NIBBLE,
        PTX_MODE_REDUCED,
        PTX_MODE_SERIAL
    } ptx_mode_e;

endpackage

// *** rtl/ptx_if.sv ***
// link between the phy transmit end and the mac transmit end
interface ptx_if;
    logic tx_clk; // transmit clock made by the phy end
    logic tx_en; // transmit enable from the mac end
    logic [ptx_pkg::PTX_TXD_W-1:0] txd; // transmit data from the mac end

    // phy end makes the clock and takes the data
    modport phy (output tx_clk, input tx_en, input txd);
    // mac end takes the clock and makes the data
    modport mac (input tx_clk, output tx_en, output txd);
endinterface

// *** rtl/ptx_clk_div.sv ***
// clock divider with separate high and low phase lengths
module ptx_clk_div #(
    parameter int CNT_W = ptx_pkg::PTX_CNT_W_DEF
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic run_in,
    input wire logic [CNT_W-1:0] high_in,
    input wire logic [CNT_W-1:0] low_in,
    output logic clk_out,
    output logic rise_out
);
    import ptx_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (CNT_W < 2) begin : g_bad_w
        $error("ptx_clk_div: counter width too small");
    end

    logic [CNT_W-1:0] cnt; // cycles left in current phase
    logic clk_q; // divided clock level
    logic [CNT_W-1:0] next_cnt;
    logic next_clk_q;

    // ------------------------------------------------------------
    // phase counting
    // ------------------------------------------------------------
    always_comb begin
        next_cnt = cnt;
        next_clk_q = clk_q;
        rise_out = 1'b0;
        if (!run_in) begin
            // stopped: hold low, restart with a rise
            next_cnt = '0;
            next_clk_q = 1'b0;
        end else if (clk_q) begin
            // high phase
            if (cnt <= CNT_W'(1)) begin
                next_clk_q = 1'b0;
                next_cnt = low_in;
            end else begin
                next_cnt = cnt - CNT_W'(1);
            end
        end else begin
            // low phase, rise when done
            if (cnt <= CNT_W'(1)) begin
                next_clk_q = 1'b1;
                next_cnt = high_in;
                rise_out = ce_in;
            end else begin
                next_cnt = cnt - CNT_W'(1);
            end
        end
    end

    // register the phase state
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt <= '0;
            clk_q <= 1'b0;
        end else if (ce_in) begin
            cnt <= next_cnt;
            clk_q <= next_clk_q;
        end
    end

    assign clk_out = clk_q;
endmodule // ptx_clk_div

// *** rtl/ptx_mac_end.sv ***
// mac end of the transmit port: splits bytes into symbols on the phy clock, or on the shared reference in two-bit mode
module ptx_mac_end (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input ptx_pkg::ptx_mode_e mode_in,
    input wire logic [ptx_pkg::PTX_BYTE_W-1:0] byte_in,
    input wire logic byte_valid_in,
    input wire logic byte_last_in,
    output logic byte_ready_out,
    output logic busy_out,
    ptx_if.mac link
);
    import ptx_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    ptx_mode_e act_mode; // mode in force
    logic clk_prev; // last seen tx clock level
    logic strobe; // drive point
    logic have; // byte being sent
    logic last; // byte being sent ends the frame
    logic gap; // idle symbol owed after a frame
    logic [PTX_BYTE_W-1:0] sh; // bits still to send
    logic [3:0] left; // bits still to send
    logic [3:0] sym_bits; // bits per symbol
    logic en_q; // enable register
    logic [PTX_TXD_W-1:0] txd_q; // data register
    logic [PTX_BYTE_W-1:0] src; // byte feeding this symbol
    ptx_mode_e next_act_mode;
    logic next_have;
    logic next_last;
    logic next_gap;
    logic [PTX_BYTE_W-1:0] next_sh;
    logic [3:0] next_left;
    logic next_en;
    logic [PTX_TXD_W-1:0] next_txd;

    // ------------------------------------------------------------
    // drive point
    // ------------------------------------------------------------
    // same-clock source: the clock is watched unsynchronised
    always_comb begin
        if (act_mode == PTX_MODE_REDUCED) begin
            strobe = ce_in;
        end else begin
            strobe = ce_in && link.tx_clk && !clk_prev;
        end
        case (act_mode)
            PTX_MODE_REDUCED: sym_bits = PTX_BITS_RED;
            PTX_MODE_SERIAL: sym_bits = PTX_BITS_SER;
            default: sym_bits = PTX_BITS_NIB;
        endcase
    end

    assign byte_ready_out = strobe && !have && !gap;
    assign busy_out = have || gap || en_q;

    // ------------------------------------------------------------
    // symbol sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_act_mode = act_mode;
        next_have = have;
        next_last = last;
        next_gap = gap;
        next_sh = sh;
        next_left = left;
        next_en = en_q;
        next_txd = txd_q;
        src = have ? sh : byte_in;
        if (!have && !gap && !en_q) begin
            next_act_mode = mode_in;
        end
        if (strobe) begin
            if (have || byte_valid_in && !gap) begin
                // send next symbol of current or newly taken byte
                next_en = 1'b1;
                case (act_mode)
                    PTX_MODE_NIBBLE: next_txd = src[3:0];
                    PTX_MODE_REDUCED: next_txd = {2'b00, src[1:0]};
                    default: next_txd = {3'b000, src[0]};
                endcase
                next_sh = src >> sym_bits;
                next_left = (have ? left : PTX_BYTE_BITS) - sym_bits;
                next_have = (next_left != 4'h0);
                next_last = have ? last : byte_last_in;
                next_gap = !next_have && next_last;
            end else begin
                // idle symbol: ends the frame
                next_en = 1'b0;
                next_txd = '0;
                next_gap = 1'b0;
            end
        end
    end

    // register sequencer state and link outputs
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            act_mode <= PTX_MODE_NIBBLE;
            clk_prev <= 1'b0;
            have <= 1'b0;
            last <= 1'b0;
            gap <= 1'b0;
            sh <= '0;
            left <= 4'h0;
            en_q <= 1'b0;
            txd_q <= '0;
        end else if (ce_in) begin
            act_mode <= next_act_mode;
            clk_prev <= link.tx_clk;
            have <= next_have;
            last <= next_last;
            gap <= next_gap;
            sh <= next_sh;
            left <= next_left;
            en_q <= next_en;
            txd_q <= next_txd;
        end
    end

    assign link.tx_en = en_q;
    assign link.txd = txd_q;
endmodule // ptx_mac_end

// *** dv/ptx_link_chk.sv ***
// assertions on the transmit link between the two ends
module ptx_link_chk (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic tx_clk,
    input wire logic tx_en,
    input wire logic [3:0] txd,
    input ptx_pkg::ptx_mode_e mode_out,
    input wire logic fast_out,
    input wire logic in_frame_out,
    input wire logic byte_valid_out,
    input wire logic frame_end_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import ptx_pkg::*;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    // ------------------------------------------------------------
    // mode decodes
    // ------------------------------------------------------------
    wire logic nf = (mode_out == PTX_MODE_NIBBLE) && fast_out; // nibble, fast
    wire logic ns = (mode_out == PTX_MODE_NIBBLE) && !fast_out; // nibble, slow
    wire logic ser = (mode_out == PTX_MODE_SERIAL); // one-bit serial
    wire logic red = (mode_out == PTX_MODE_REDUCED); // two-bit

    // ------------------------------------------------------------
    // clock shapes
    // ------------------------------------------------------------
    sequence s_slow_hi;
        tx_clk [*8] ##1 tx_clk [*2] ##1 !tx_clk;
    endsequence
    sequence s_ser_cyc;
        tx_clk [*2] ##1 !tx_clk [*3] ##1 tx_clk;
    endsequence

    AST_FAST_CLK: assert property (nf && tx_en && $rose(tx_clk) |=> !tx_clk ##1 tx_clk)
        else $error("fast nibble clock period wrong");
    AST_SLOW_CLK: assert property (ns && tx_en && $rose(tx_clk) |-> s_slow_hi)
        else $error("slow nibble clock high phase wrong");
    AST_RED_CLK: assert property (red && in_frame_out |-> !tx_clk)
        else $error("clock toggles in two-bit mode");
    AST_SER_CLK: assert property (ser && tx_en && $rose(tx_clk) |-> s_ser_cyc)
        else $error("serial clock period wrong");

    // ------------------------------------------------------------
    // data acceptance
    // ------------------------------------------------------------
    AST_BYTE_EN: assert property (byte_valid_out |-> $past(tx_en))
        else $error("byte taken with enable low");
    AST_BYTE_EDGE: assert property (byte_valid_out && !red |-> $rose(tx_clk))
        else $error("byte not taken on clock rise");
    AST_END_EN: assert property (frame_end_out |-> !$past(tx_en) && $past(in_frame_out))
        else $error("frame end without enable low");
    AST_SER_UNUSED: assert property (ser && tx_en |-> txd[3:1] == 3'h0)
        else $error("unused lines driven in serial mode");
    AST_RED_UNUSED: assert property (red && tx_en |-> txd[3:2] == 2'h0)
        else $error("unused lines driven in two-bit mode");
    AST_MODE_HOLD: assert property (in_frame_out |-> $stable(mode_out) && $stable(fast_out))
        else $error("mode changed inside a frame");
endmodule // ptx_link_chk

// *** dv/testbench.sv ***
// bench: mac and phy ends joined, plus a hand-driven phy end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ptx_pkg::*;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic core_clk_in = 0;
    logic rst_in = 1;
    logic ce = 1; // clock enable, always run
    logic fast = 1; // requested speed
    ptx_mode_e mode = PTX_MODE_NIBBLE; // requested mode
    logic [7:0] b_in = 8'h00;
    logic b_val = 0;
    logic b_last = 0;
    logic b_rdy, busy;
    logic [7:0] byte_out, byte2;
    logic byte_valid_out, frame_start_out, frame_end_out, frag_out, in_frame_out, fast_out;
    logic val2, end2, frag2;
    ptx_mode_e mode_out;
    logic [7:0] got_q[$], got2_q[$]; // bytes seen on each phy end
    int starts, ends, frags, frags2;
    int err_total = 0;
    int n_tests = 0;

    ptx_if link_if(); // joined link
    ptx_if link2_if(); // hand-driven link

    ptx_phy_end ptx_phy_end_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce), .mode_in(mode),
        .fast_in(fast), .link(link_if), .byte_out(byte_out), .byte_valid_out(byte_valid_out),
        .frame_start_out(frame_start_out), .frame_end_out(frame_end_out), .frag_out(frag_out),
        .in_frame_out(in_frame_out), .mode_out(mode_out), .fast_out(fast_out));
    ptx_mac_end ptx_mac_end_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce), .mode_in(mode),
        .byte_in(b_in), .byte_valid_in(b_val), .byte_last_in(b_last), .byte_ready_out(b_rdy),
        .busy_out(busy), .link(link_if));
    ptx_phy_end ptx_phy_end2_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce),
        .mode_in(PTX_MODE_REDUCED), .fast_in(fast), .link(link2_if), .byte_out(byte2),
        .byte_valid_out(val2), .frame_start_out(), .frame_end_out(end2), .frag_out(frag2),
        .in_frame_out(), .mode_out(), .fast_out());
    ptx_link_chk ptx_link_chk_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .tx_clk(link_if.tx_clk),
        .tx_en(link_if.tx_en), .txd(link_if.txd), .mode_out(mode_out), .fast_out(fast_out),
        .in_frame_out(in_frame_out), .byte_valid_out(byte_valid_out), .frame_end_out(frame_end_out));

    // ------------------------------------------------------------
    // clock and output collection
    // ------------------------------------------------------------
    initial forever #10 core_clk_in = ~core_clk_in;

    // pulses stand one cycle; a fragment counts only with its frame end
    always @(negedge core_clk_in) begin
        if (byte_valid_out) got_q.push_back(byte_out);
        if (val2) got2_q.push_back(byte2);
        starts += int'(frame_start_out === 1'b1);
        ends += int'(frame_end_out === 1'b1);
        frags += int'(frag_out === 1'b1);
        frags2 += int'(frag2 === 1'b1 && end2 === 1'b1);
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // request a mode while idle and see it taken
    task automatic set_mode(input ptx_mode_e m, input logic f);
        @(negedge core_clk_in);
        mode = m;
        fast = f;
        repeat (40) @(negedge core_clk_in);
        chk("mode_out", m, mode_out);
        if (m == PTX_MODE_NIBBLE) chk("fast_out", f, fast_out);
    endtask

    // count clock rises over 100 core cycles
    task automatic clk_rate(input int exp);
        int n = 0;
        logic p;
        p = link_if.tx_clk;
        repeat (100) begin
            @(negedge core_clk_in);
            if (link_if.tx_clk === 1'b1 && p === 1'b0) n++;
            p = link_if.tx_clk;
        end
        chk("tx_clk rises", exp, n);
    endtask

    // send n bytes as one frame and compare what the phy packed
    task automatic send_frame(input int n, input logic [7:0] base);
        logic [7:0] exp_q[$];
        int k = 0;
        got_q.delete();
        starts = 0;
        ends = 0;
        frags = 0;
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk_in);
            b_in = base + 8'(i * 59);
            b_val = 1;
            b_last = (i == n - 1);
            exp_q.push_back(b_in);
            #1;
            while (b_rdy !== 1'b1) begin
                @(negedge core_clk_in);
                #1;
            end
        end
        @(negedge core_clk_in);
        b_val = 0;
        b_last = 0;
        while ((busy !== 1'b0 || in_frame_out !== 1'b0) && k < 2000) begin
            @(negedge core_clk_in);
            k++;
        end
        repeat (3) @(negedge core_clk_in);
        chk("frame drained", 1, k < 2000);
        chk("byte count", n, got_q.size());
        foreach (exp_q[i]) chk("byte", exp_q[i], got_q[i]);
        chk("frame starts", 1, starts);
        chk("frame ends", 1, ends);
        chk("fragments", 0, frags);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_nib_fast();
        set_mode(PTX_MODE_NIBBLE, 1);
        clk_rate(50);
        send_frame(3, 8'h3c);
        $display("test nibble fast done");
    endtask

    task automatic t_nib_slow();
        set_mode(PTX_MODE_NIBBLE, 0);
        clk_rate(5);
        send_frame(2, 8'ha5);
        $display("test nibble slow done");
    endtask

    task automatic t_reduced();
        set_mode(PTX_MODE_REDUCED, 1);
        clk_rate(0);
        send_frame(4, 8'h0f);
        $display("test two-bit done");
    endtask

    task automatic t_serial();
        set_mode(PTX_MODE_SERIAL, 1);
        clk_rate(20);
        send_frame(2, 8'h81);
        $display("test serial done");
    endtask

    // ask for another mode mid-frame: it waits for the frame end
    task automatic t_mode_hold();
        fork
            send_frame(3, 8'h66);
            begin
                wait (in_frame_out === 1'b1);
                @(negedge core_clk_in);
                mode = PTX_MODE_NIBBLE;
                while (in_frame_out === 1'b1) begin
                    @(negedge core_clk_in);
                    if (in_frame_out === 1'b1) chk("held mode", PTX_MODE_SERIAL, mode_out);
                end
            end
        join
        repeat (40) @(negedge core_clk_in);
        chk("mode after frame", PTX_MODE_NIBBLE, mode_out);
        $display("test mode hold done");
    endtask

    // hand-driven two-bit link: idle junk, unused lines set, partial byte
    task automatic t_fault();
        logic [7:0] d = 8'h5a;
        got2_q.delete();
        frags2 = 0;
        for (int i = 0; i < 14; i++) begin
            @(negedge core_clk_in);
            link2_if.tx_en = (i >= 6 && i < 12);
            link2_if.txd = (i >= 6 && i < 12) ? {2'b11, 2'(d >> (2 * (i - 6)))} : 4'(i * 5 + 3);
        end
        repeat (4) @(negedge core_clk_in);
        chk("faulty link bytes", 1, got2_q.size());
        chk("faulty link byte", 8'h5a, got2_q[0]);
        chk("faulty link fragment", 1, frags2);
        $display("test hand-driven link done");
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        link2_if.tx_en = 0;
        link2_if.txd = 4'h0;
        repeat (10) @(negedge core_clk_in);
        rst_in = 0;
        t_nib_fast();
        t_nib_slow();
        t_reduced();
        t_serial();
        t_mode_hold();
        t_fault();
        test_done();
    end

    // run is about a thousand cycles; cut a hang at ten thousand
    initial begin
        #200_000;
        err_total++;
        $display("mismatch watchdog expected finish seen hang");
        test_done();
    end
endmodule // testbench
